//--- ipm_params.svh
// ipm_params.svh: constants for the inactivity power manager
// assumes: included by bare name; only `define definitions inside
`ifndef IPM_PARAMS_SVH
`define IPM_PARAMS_SVH

// ----------------------------------------------------------------
// time base
// ----------------------------------------------------------------
`define IPM_CLK_PERIOD_NS 100
`define IPM_TICK_PERIOD_NS 1000000000
`define IPM_CYC_PER_TICK (`IPM_TICK_PERIOD_NS / `IPM_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// select codes and widths
// ----------------------------------------------------------------
`define IPM_SEL_W 3
`define IPM_RING_SEL_W 2
`define IPM_SECS_W 12
`define IPM_SEL_DISABLED 3'h0
`define IPM_RING_DISABLED 2'h0

// ----------------------------------------------------------------
// timeout tables in seconds, code 0 is disabled
// ----------------------------------------------------------------
`define IPM_DOZE_S1 12'h001
`define IPM_DOZE_S2 12'h004
`define IPM_DOZE_S3 12'h008
`define IPM_DOZE_S4 12'h010
`define IPM_SLEEP_M1 12'h03c
`define IPM_SLEEP_M2 12'h078
`define IPM_SLEEP_M3 12'h0f0
`define IPM_SLEEP_M4 12'h168
`define IPM_SLEEP_M5 12'h1e0
`define IPM_SLEEP_M6 12'h2d0
`define IPM_SLEEP_M7 12'h3c0
`define IPM_SUSP_M1 12'h12c
`define IPM_SUSP_M2 12'h258
`define IPM_SUSP_M3 12'h384
`define IPM_SUSP_M4 12'h4b0
`define IPM_SUSP_M5 12'h708
`define IPM_SUSP_M6 12'h960
`define IPM_SUSP_M7 12'he10
`define IPM_DISK_MINUTE 12'h03c
`define IPM_VID_S1 12'h005
`define IPM_VID_S2 12'h00a
`define IPM_VID_S3 12'h00f
`define IPM_VID_S4 12'h01e
`define IPM_VID_S5 12'h02d
`define IPM_VID_S6 12'h03c
`define IPM_VID_S7 12'h05a

// ----------------------------------------------------------------
// warning beeps: seconds of beeping before suspend
// ----------------------------------------------------------------
`define IPM_WARN_SECS 12'h004

`endif

//--- ipm_pkg.sv
// ipm_pkg.sv: types shared by the inactivity power manager
// assumes: ipm_params.svh is on the include path
`include "ipm_params.svh"
`default_nettype none

package ipm_pkg;

    // gray along full -> doze -> sleep -> suspend
    typedef enum logic [1:0]
    {
        IPM_FULL    = 2'h0,
        IPM_DOZE    = 2'h1,
        IPM_SLEEP   = 2'h3,
        IPM_SUSPEND = 2'h2
    } ipm_state_e;

    typedef logic [`IPM_SECS_W-1:0] ipm_secs_t;

endpackage

`default_nettype wire

//--- ipm_tick_gen.sv
// ipm_tick_gen.sv: one-second tick from the system clock
// assumes: clk_in is the system clock; tick is a one-cycle pulse
`include "ipm_params.svh"
`default_nettype none

module ipm_tick_gen
#(
    parameter int CYCLES = `IPM_CYC_PER_TICK
)
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    output logic tick_out
);

    logic [31:0] count;

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            count <= 32'h0;
            tick_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (count == 32'(CYCLES - 1))
            begin
                count <= 32'h0;
                tick_out <= 1'b1;
            end
            else
            begin
                count <= count + 32'h1;
                tick_out <= 1'b0;
            end
        end
    end

endmodule // ipm_tick_gen

`default_nettype wire

//--- ipm_power_manager.sv
// ipm_power_manager.sv: inactivity power manager, doze/sleep/suspend chain plus disk and display timers
// assumes: all inputs synchronous to clk_in; activity inputs are levels, high while activity is seen
//
// Overview of operation
// - power states only while management is enabled
// - doze after idle doze timeout
// - doze advances to sleep after sleep timeout
// - sleep advances to suspend after suspend timeout
// - disk standby after disk idle minutes
// - display standby after display idle timeout
// - activity restores display from standby at once
// - counted modem rings wake processor from suspend
// - optional warning beeps before suspend entry
`include "ipm_params.svh"
`default_nettype none

module ipm_power_manager
#(
    parameter int CYCLES_PER_SEC = `IPM_CYC_PER_TICK
)
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic pm_enable_in,
    input wire logic [`IPM_SEL_W-1:0] doze_sel_in,
    input wire logic [`IPM_SEL_W-1:0] sleep_sel_in,
    input wire logic [`IPM_SEL_W-1:0] suspend_sel_in,
    input wire logic [`IPM_SEL_W-1:0] disk_sel_in,
    input wire logic [`IPM_SEL_W-1:0] video_sel_in,
    input wire logic [`IPM_RING_SEL_W-1:0] ring_sel_in,
    input wire logic warn_enable_in,
    input wire logic activity_in,
    input wire logic disk_activity_in,
    input wire logic ring_in,
    output logic [1:0] pm_state_out,
    output logic doze_out,
    output logic sleep_out,
    output logic suspend_out,
    output logic disk_standby_out,
    output logic video_standby_out,
    output logic cpu_wake_out,
    output logic beep_out
);

    // ----------------------------------------------------------------
    // time base
    // ----------------------------------------------------------------
    logic tick;

    ipm_tick_gen #(.CYCLES(CYCLES_PER_SEC)) u_tick
    (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .tick_out(tick)
    );

    // ----------------------------------------------------------------
    // timeout decode, zero means disabled
    // ----------------------------------------------------------------
    ipm_pkg::ipm_secs_t doze_limit;
    ipm_pkg::ipm_secs_t sleep_limit;
    ipm_pkg::ipm_secs_t susp_limit;
    ipm_pkg::ipm_secs_t disk_limit;
    ipm_pkg::ipm_secs_t vid_limit;
    logic [2:0] ring_limit;

    always_comb
    begin
        unique case (doze_sel_in)
            3'h1: doze_limit = `IPM_DOZE_S1;
            3'h2: doze_limit = `IPM_DOZE_S2;
            3'h3: doze_limit = `IPM_DOZE_S3;
            3'h4: doze_limit = `IPM_DOZE_S4;
            default: doze_limit = 12'h000;
        endcase
        unique case (sleep_sel_in)
            3'h1: sleep_limit = `IPM_SLEEP_M1;
            3'h2: sleep_limit = `IPM_SLEEP_M2;
            3'h3: sleep_limit = `IPM_SLEEP_M3;
            3'h4: sleep_limit = `IPM_SLEEP_M4;
            3'h5: sleep_limit = `IPM_SLEEP_M5;
            3'h6: sleep_limit = `IPM_SLEEP_M6;
            3'h7: sleep_limit = `IPM_SLEEP_M7;
            default: sleep_limit = 12'h000;
        endcase
        unique case (suspend_sel_in)
            3'h1: susp_limit = `IPM_SUSP_M1;
            3'h2: susp_limit = `IPM_SUSP_M2;
            3'h3: susp_limit = `IPM_SUSP_M3;
            3'h4: susp_limit = `IPM_SUSP_M4;
            3'h5: susp_limit = `IPM_SUSP_M5;
            3'h6: susp_limit = `IPM_SUSP_M6;
            3'h7: susp_limit = `IPM_SUSP_M7;
            default: susp_limit = 12'h000;
        endcase
        unique case (video_sel_in)
            3'h1: vid_limit = `IPM_VID_S1;
            3'h2: vid_limit = `IPM_VID_S2;
            3'h3: vid_limit = `IPM_VID_S3;
            3'h4: vid_limit = `IPM_VID_S4;
            3'h5: vid_limit = `IPM_VID_S5;
            3'h6: vid_limit = `IPM_VID_S6;
            3'h7: vid_limit = `IPM_VID_S7;
            default: vid_limit = 12'h000;
        endcase
        disk_limit = 12'(`IPM_DISK_MINUTE * disk_sel_in);
        unique case (ring_sel_in)
            2'h1: ring_limit = 3'h1;
            2'h2: ring_limit = 3'h2;
            2'h3: ring_limit = 3'h4;
            default: ring_limit = 3'h0;
        endcase
    end

    // ----------------------------------------------------------------
    // state chain
    // ----------------------------------------------------------------
    ipm_pkg::ipm_state_e state;
    ipm_pkg::ipm_state_e next_state;
    ipm_pkg::ipm_secs_t idle_secs;
    logic [2:0] ring_count;
    logic ring_prev;
    logic ring_rise;
    logic ring_wake;
    logic in_warn;

    assign ring_rise = ring_in && !ring_prev;
    // the ring that completes the count wakes the processor
    assign ring_wake = (ring_limit != 3'h0) && ring_rise && (ring_count + 3'h1 >= ring_limit);
    // warning window: the last few seconds of sleep before suspend
    assign in_warn = (state == ipm_pkg::IPM_SLEEP) && (susp_limit != 12'h000)
                     && (idle_secs + `IPM_WARN_SECS >= susp_limit);

    always_comb
    begin
        next_state = state;
        if (!pm_enable_in)
            next_state = ipm_pkg::IPM_FULL;
        else
        begin
            unique case (state)
                ipm_pkg::IPM_FULL:
                    if (!activity_in && doze_limit != 12'h000 && idle_secs >= doze_limit)
                        next_state = ipm_pkg::IPM_DOZE;
                ipm_pkg::IPM_DOZE:
                    if (activity_in)
                        next_state = ipm_pkg::IPM_FULL;
                    else if (sleep_limit != 12'h000 && idle_secs >= sleep_limit)
                        next_state = ipm_pkg::IPM_SLEEP;
                ipm_pkg::IPM_SLEEP:
                    if (activity_in)
                        next_state = ipm_pkg::IPM_FULL;
                    else if (susp_limit != 12'h000 && idle_secs >= susp_limit)
                        next_state = ipm_pkg::IPM_SUSPEND;
                // activity also wakes, so a user never stays locked out
                ipm_pkg::IPM_SUSPEND:
                    if (activity_in || ring_wake)
                        next_state = ipm_pkg::IPM_FULL;
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            state <= ipm_pkg::IPM_FULL;
        else if (clk_en_in)
            state <= next_state;
    end

    // idle seconds in the current state; restarts on activity or state change
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            idle_secs <= 12'h000;
        else if (clk_en_in)
        begin
            if (activity_in || next_state != state || !pm_enable_in)
                idle_secs <= 12'h000;
            else if (tick && idle_secs != 12'hfff)
                idle_secs <= idle_secs + 12'h001;
        end
    end

    // rings count only in suspend
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            ring_prev <= 1'b0;
            ring_count <= 3'h0;
        end
        else if (clk_en_in)
        begin
            ring_prev <= ring_in;
            if (state != ipm_pkg::IPM_SUSPEND || next_state != ipm_pkg::IPM_SUSPEND)
                ring_count <= 3'h0;
            else if (ring_rise)
                ring_count <= ring_count + 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // state outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            pm_state_out <= 2'h0;
            doze_out <= 1'b0;
            sleep_out <= 1'b0;
            suspend_out <= 1'b0;
            cpu_wake_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            pm_state_out <= next_state;
            doze_out <= (next_state == ipm_pkg::IPM_DOZE);
            sleep_out <= (next_state == ipm_pkg::IPM_SLEEP);
            suspend_out <= (next_state == ipm_pkg::IPM_SUSPEND);
            cpu_wake_out <= (state == ipm_pkg::IPM_SUSPEND) && (next_state == ipm_pkg::IPM_FULL);
        end
    end

    // beeper toggles once a second through the warning window
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            beep_out <= 1'b0;
        else if (clk_en_in)
        begin
            if (!warn_enable_in || !in_warn || next_state != ipm_pkg::IPM_SLEEP)
                beep_out <= 1'b0;
            else if (tick)
                beep_out <= !beep_out;
        end
    end

    // ----------------------------------------------------------------
    // standby timers: channel 0 disk, channel 1 display
    // ----------------------------------------------------------------
    // the disk restarts only on its own accesses, the display only on activity_in
    logic dev_clear [2];
    logic dev_standby [2];
    ipm_pkg::ipm_secs_t dev_limit [2];
    ipm_pkg::ipm_secs_t dev_secs [2];

    assign dev_clear[0] = disk_activity_in || disk_limit == 12'h000;
    assign dev_clear[1] = activity_in || vid_limit == 12'h000;
    assign dev_limit[0] = disk_limit;
    assign dev_limit[1] = vid_limit;

    for (genvar ch = 0; ch < 2; ch++)
    begin : g_standby
        always_ff @(posedge clk_in or posedge sys_rst_in)
        begin
            if (sys_rst_in)
            begin
                dev_secs[ch] <= 12'h000;
                dev_standby[ch] <= 1'b0;
            end
            else if (clk_en_in)
            begin
                if (dev_clear[ch])
                begin
                    dev_secs[ch] <= 12'h000;
                    dev_standby[ch] <= 1'b0;
                end
                else
                begin
                    if (tick && dev_secs[ch] != 12'hfff)
                        dev_secs[ch] <= dev_secs[ch] + 12'h001;
                    if (dev_secs[ch] >= dev_limit[ch])
                        dev_standby[ch] <= 1'b1;
                end
            end
        end
    end

    assign disk_standby_out = dev_standby[0];
    assign video_standby_out = dev_standby[1];

endmodule // ipm_power_manager

`default_nettype wire

//--- ipm_power_manager_properties.sv
// ipm_power_manager_properties.sv: port checks for the power manager
// assumes: bound into ipm_power_manager; one clock, async active-high reset
`include "ipm_params.svh"
`default_nettype none

module ipm_power_manager_properties
#(
    parameter int CYCLES_PER_SEC = 4
)
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic pm_enable_in,
    input wire logic [`IPM_SEL_W-1:0] sleep_sel_in,
    input wire logic activity_in,
    input wire logic [1:0] pm_state_out,
    input wire logic doze_out,
    input wire logic sleep_out,
    input wire logic suspend_out,
    input wire logic video_standby_out,
    input wire logic cpu_wake_out,
    input wire logic beep_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    // ----
    // state chain
    // ----
    pm_off_a: assert property (
        !pm_enable_in && clk_en_in |=> pm_state_out == 2'h0) else $error("power state kept while disabled");
    from_full_a: assert property (
        pm_state_out == 2'h0 |=> pm_state_out inside {2'h0, 2'h1}) else $error("full skipped doze");
    from_doze_a: assert property (
        pm_state_out == 2'h1 |=> pm_state_out != 2'h2) else $error("doze jumped to suspend");
    from_sleep_a: assert property (
        pm_state_out == 2'h3 |=> pm_state_out != 2'h1) else $error("sleep fell back to doze");
    act_back_a: assert property (
        activity_in && clk_en_in |=> pm_state_out == 2'h0) else $error("activity did not restore full");
    sleep_off_a: assert property (
        sleep_sel_in == 3'h0 && pm_state_out == 2'h1 |=> pm_state_out != 2'h3) else $error("disabled sleep taken");
    // the pulse must follow a suspend exit and last one cycle only
    wake_pulse_a: assert property (
        $rose(cpu_wake_out) |-> pm_state_out == 2'h0 && $past(pm_state_out) == 2'h2)
        else $error("wake pulse not tied to suspend exit");
    wake_once_a: assert property (
        cpu_wake_out && clk_en_in |=> !cpu_wake_out) else $error("wake pulse longer than one cycle");
    state_flags_a: assert property (
        {doze_out, sleep_out, suspend_out} == {pm_state_out == 2'h1, pm_state_out == 2'h3, pm_state_out == 2'h2})
        else $error("state flags disagree with state code");
    video_act_a: assert property (
        activity_in && clk_en_in |=> !video_standby_out) else $error("display stayed in standby");
    beep_sleep_a: assert property (
        beep_out |-> pm_state_out == 2'h3) else $error("beep outside sleep");

    doze_c: cover property (pm_state_out == 2'h1);
    susp_c: cover property (pm_state_out == 2'h2);
    wake_c: cover property (cpu_wake_out);
    video_c: cover property (video_standby_out);
endmodule // ipm_power_manager_properties

bind ipm_power_manager ipm_power_manager_properties #(.CYCLES_PER_SEC(CYCLES_PER_SEC)) i_props (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in), .pm_enable_in(pm_enable_in),
    .sleep_sel_in(sleep_sel_in), .activity_in(activity_in), .pm_state_out(pm_state_out),
    .doze_out(doze_out), .sleep_out(sleep_out), .suspend_out(suspend_out),
    .video_standby_out(video_standby_out), .cpu_wake_out(cpu_wake_out), .beep_out(beep_out));

`default_nettype wire

//--- ipm_ring_src.sv
// ipm_ring_src.sv: modem ring source standing on the far side
// assumes: go_in is a one-cycle request; line idles low between rings
`default_nettype none

module ipm_ring_src
(
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic [2:0] count_in,
    output logic ring_out,
    output logic busy_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // each ring is one rising edge, held long enough to be sampled
    initial
    begin
        ring_out = 1'b0;
        busy_out = 1'b0;
        forever
        begin
            @(posedge clk_in);
            if (go_in)
            begin
                busy_out <= 1'b1;
                repeat (count_in)
                begin
                    ring_out <= 1'b1;
                    repeat (3) @(posedge clk_in);
                    ring_out <= 1'b0;
                    repeat (3) @(posedge clk_in);
                end
                busy_out <= 1'b0;
            end
        end
    end
endmodule // ipm_ring_src

`default_nettype wire

//--- ipm_power_manager_tb.sv
// ipm_power_manager_tb.sv: self-checking bench for the power manager
// assumes: one second shortened to CPS clocks; ring source model alongside
`include "ipm_params.svh"
`default_nettype none

module ipm_power_manager_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CPS = 4;
    logic clk_in, sys_rst_in, clk_en_in, pm_enable_in, warn_enable_in, activity_in, disk_activity_in, ring_in;
    logic [2:0] doze_sel_in, sleep_sel_in, suspend_sel_in, disk_sel_in, video_sel_in, ring_cnt;
    logic [1:0] ring_sel_in, pm_state_out;
    logic doze_out, sleep_out, suspend_out, disk_standby_out, video_standby_out, cpu_wake_out, beep_out;
    logic ring_go, ring_busy;
    int failures = 0;
    int cmp_count = 0;
    int beeps = 0;
    int wakes = 0;
    int sl, su, dk;
    // timeouts in seconds, and ring counts, per select code, code 0 disabled
    int doze_s[5] = '{0, 1, 4, 8, 16};
    int sleep_s[8] = '{0, 60, 120, 240, 360, 480, 720, 960};
    int susp_s[8] = '{0, 300, 600, 900, 1200, 1800, 2400, 3600};
    int video_s[8] = '{0, 5, 10, 15, 30, 45, 60, 90};
    int rings[4] = '{0, 1, 2, 4};

    ipm_power_manager #(.CYCLES_PER_SEC(CPS)) i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in), .pm_enable_in(pm_enable_in), .doze_sel_in(doze_sel_in), .sleep_sel_in(sleep_sel_in),
        .suspend_sel_in(suspend_sel_in), .disk_sel_in(disk_sel_in), .video_sel_in(video_sel_in),
        .ring_sel_in(ring_sel_in), .warn_enable_in(warn_enable_in), .activity_in(activity_in),
        .disk_activity_in(disk_activity_in), .ring_in(ring_in), .pm_state_out(pm_state_out),
        .doze_out(doze_out), .sleep_out(sleep_out), .suspend_out(suspend_out),
        .disk_standby_out(disk_standby_out), .video_standby_out(video_standby_out),
        .cpu_wake_out(cpu_wake_out), .beep_out(beep_out));
    ipm_ring_src i_ring (.clk_in(clk_in), .go_in(ring_go), .count_in(ring_cnt), .ring_out(ring_in),
        .busy_out(ring_busy));

    always @(posedge beep_out) beeps++;
    always @(posedge cpu_wake_out) wakes++;

    initial
    begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    // ----
    // helpers
    // ----
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic cmp(input logic [1:0] got, input logic [1:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [1:0] obs(input int k);
        case (k)
            1: return {1'b0, video_standby_out};
            2: return {1'b0, disk_standby_out};
            default: return pm_state_out;
        endcase
    endfunction

    // tick phase is unknown, so check one second early, then wait boundedly
    task automatic step(input int secs, input int k, input logic [1:0] was, input logic [1:0] now);
        int i;
        if (secs > 1)
        begin
            cyc((secs - 1) * CPS - 2);
            cmp(obs(k), was);
        end
        i = 0;
        while (obs(k) !== now && i < 3 * CPS)
        begin
            cyc(1);
            i++;
        end
        cmp(obs(k), now);
    endtask

    task automatic act();
        activity_in = 1'b1;
        cyc(1);
        activity_in = 1'b0;
    endtask

    task automatic ring(input int n);
        int i;
        ring_cnt = 3'(n);
        ring_go = 1'b1;
        cyc(1);
        ring_go = 1'b0;
        cyc(1);
        i = 0;
        while (ring_busy && i < 40)
        begin
            cyc(1);
            i++;
        end
        cyc(2);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // whole plan stays near 30000 cycles; twice that means a hang
    initial
    begin
        repeat (60000) @(posedge clk_in);
        failures++;
        results();
    end

    initial
    begin
        {sys_rst_in, pm_enable_in, warn_enable_in, activity_in, disk_activity_in, ring_go} = 6'h20;
        {doze_sel_in, sleep_sel_in, suspend_sel_in, disk_sel_in, video_sel_in, ring_cnt} = 18'h0;
        ring_sel_in = 2'h0;
        clk_en_in = 1'b1;
        sl = $urandom(32'h60faeff2);
        repeat (6) @(posedge clk_in);
        #1;
        sys_rst_in = 1'b0;
        cmp(pm_state_out, 2'h0);
        cmp({disk_standby_out, video_standby_out}, 2'h0);
        doze_sel_in = 3'h1;
        cyc(5 * CPS);
        cmp(pm_state_out, 2'h0);
        pm_enable_in = 1'b1;
        act();
        step(1, 0, 2'h0, 2'h1);
        pm_enable_in = 1'b0;
        cyc(2);
        cmp(pm_state_out, 2'h0);
        pm_enable_in = 1'b1;
        clk_en_in = 1'b0;
        cyc(8 * CPS);
        cmp(pm_state_out, 2'h0);
        clk_en_in = 1'b1;
        step(1, 0, 2'h0, 2'h1);
        cmp({doze_out, suspend_out}, 2'h2);
        $display("test master enable done");
        for (int c = 1; c <= 4; c++)
        begin
            doze_sel_in = 3'(c);
            act();
            step(doze_s[c], 0, 2'h0, 2'h1);
            act();
            cmp(pm_state_out, 2'h0);
        end
        doze_sel_in = 3'h5;
        act();
        cyc(20 * CPS);
        cmp(pm_state_out, 2'h0);
        $display("test doze timeouts done");
        doze_sel_in = 3'h1;
        act();
        step(1, 0, 2'h0, 2'h1);
        cyc(70 * CPS);
        cmp(pm_state_out, 2'h1);
        sleep_sel_in = 3'h1;
        act();
        step(1, 0, 2'h0, 2'h1);
        step(sleep_s[1], 0, 2'h1, 2'h3);
        cyc(400 * CPS);
        cmp(pm_state_out, 2'h3);
        $display("test disabled steps done");
        doze_sel_in = 3'h0;
        for (int c = 1; c <= 7; c++)
        begin
            video_sel_in = 3'(c);
            act();
            step(video_s[c], 1, 2'h0, 2'h1);
            act();
            cmp(obs(1), 2'h0);
        end
        video_sel_in = 3'h0;
        dk = $urandom_range(7, 1);
        disk_sel_in = 3'(dk);
        disk_activity_in = 1'b1;
        cyc(1);
        disk_activity_in = 1'b0;
        step(dk * 60, 2, 2'h0, 2'h1);
        disk_sel_in = 3'h0;
        $display("test display and disk done");
        for (int r = 1; r <= 3; r++)
        begin
            sl = $urandom_range(7, 1);
            su = $urandom_range(3, 1);
            {doze_sel_in, sleep_sel_in, suspend_sel_in} = {3'h1, 3'(sl), 3'(su)};
            ring_sel_in = 2'(r);
            warn_enable_in = r[0];
            act();
            step(1, 0, 2'h0, 2'h1);
            step(sleep_s[sl], 0, 2'h1, 2'h3);
            cmp({doze_out, sleep_out}, 2'h1);
            beeps = 0;
            step(susp_s[su], 0, 2'h3, 2'h2);
            cmp({sleep_out, suspend_out}, 2'h1);
            cmp({1'b0, beeps != 0}, {1'b0, warn_enable_in});
            wakes = 0;
            doze_sel_in = 3'h0;
            ring(rings[r] - 1);
            cmp(pm_state_out, 2'h2);
            ring(1);
            cmp({1'b0, wakes == 1}, 2'h1);
            cmp(pm_state_out, 2'h0);
        end
        $display("test suspend and ring wake done");
        results();
    end
endmodule // ipm_power_manager_tb

`default_nettype wire
